// ==== rtl/ccs_pkg.sv ====
package ccs_pkg;

    // register byte addresses on the apb window
    localparam logic [7:0] OFS_MASTER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MASTER_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TX_STATUS      = 8'h08;
    localparam logic [7:0] OFS_TX_PRIORITY    = 8'h0c;
    localparam logic [7:0] OFS_RX_FIFO        = 8'h10;
    localparam logic [7:0] OFS_IRQ_CONTROL    = 8'h14;

    // reset values
    localparam logic [7:0] RST_MASTER_CONTROL = 8'h02;
    localparam logic [7:0] RST_IRQ_CONTROL    = 8'h00;

    // master control fields
    localparam int MCR_AUTO_BUSOFF = 6;
    localparam int MCR_AUTO_WAKEUP = 5;
    localparam int MCR_NO_RETX     = 4;
    localparam int MCR_FIFO_LOCK   = 3;
    localparam int MCR_TX_ORDER    = 2;
    localparam int MCR_SLEEP_REQ   = 1;
    localparam int MCR_INIT_REQ    = 0;

    // master status fields
    localparam int MSR_RX_ACTIVE = 5;
    localparam int MSR_TX_ACTIVE = 4;
    localparam int MSR_WAKEUP    = 3;
    localparam int MSR_ERROR     = 2;
    localparam int MSR_SLEEP_ACK = 1;
    localparam int MSR_INIT_ACK  = 0;

    // tx status fields (success flags sit at 4 + mailbox)
    localparam int TSR_TX_OK_BASE = 4;
    localparam int TSR_DONE_BASE  = 0;

    // rx fifo fields
    localparam int RFR_RELEASE = 5;
    localparam int RFR_OVERRUN = 4;
    localparam int RFR_FULL    = 3;

    // irq control fields
    localparam int ICR_WAKEUP_EN  = 7;
    localparam int ICR_ERROR_EN   = 6;
    localparam int ICR_BUSOFF_REL = 0;

    // bit-time counts and fifo depth in messages
    localparam logic [3:0] RECESSIVE_RUN = 4'd11;
    localparam logic [7:0] BUSOFF_RUNS   = 8'd128;
    localparam logic [1:0] FIFO_DEPTH    = 2'd3;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_INIT,
        MODE_SYNC,
        MODE_NORMAL
    } ccs_mode_t;

    // events and state from the frame engine, same clock
    typedef struct packed {
        logic        bitTick;
        logic        sofSeen;
        logic        rxActive;
        logic        txActive;
        logic        busOffEnter;
        logic        errorSet;
        logic        rxAccepted;
        logic [1:0]  txReq;
        logic [1:0]  txOk;
        logic [1:0]  txFail;
        logic [1:0]  abortDone;
        logic [10:0] id0;
        logic [10:0] id1;
    } ccs_engine_in_t;

    // steering towards the frame engine
    typedef struct packed {
        logic       initMode;
        logic       sleepMode;
        logic       busOff;
        logic       txGo;
        logic       txSel;
        logic       fifoStore;
        logic       fifoOverwrite;
        logic       fifoRelease;
        logic [1:0] fifoCount;
    } ccs_engine_out_t;

endpackage

// ==== rtl/ccs_control_status.sv ====
`timescale 1ns/100ps
// Operation
// - auto recovery leaves bus-off after 128 runs of 11 recessive bits
// - auto wake-up exits sleep on activity, clearing request and ack
// - no-retransmit sends once; otherwise retry until success
// - full fifo: overwrite when unlocked, discard when locked
// - pending mailboxes ordered by identifier or by request order
// - sleep entered only after current frame ends; ack follows
// - auto wake-up clears sleep request on start of frame
// - leaving init waits 11 recessive bits, then clears init ack
// - init entered after current frame ends, then init ack set
// - clearable flags clear on write of one, zero leaves them
// - status shows receiver and transmitter activity
// - start of frame in sleep sets wake-up flag, may interrupt
// - engine error sets error flag, may interrupt when enabled
// - sleep ack high while in sleep, low on exit
// - success flag set on good send, cleared on request or clear
// - request-done flag set when transmit or abort finishes
// - lowest-priority flag only when more than one mailbox pending
// - mailbox-empty flag high when no request pending
// - code gives next free mailbox, else lowest-priority one
// - fifo release ignored when nothing pending
// - release bit clears itself once release is done
// - pending count up on store, down on release
// - full flag set at three messages, cleared by one or release
// - overrun flag set when accepted message meets full fifo
module ccs_control_status (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     canRx,
    input  wire ccs_pkg::ccs_engine_in_t  eng,
    output ccs_pkg::ccs_engine_out_t      ctl,
    output logic                          statusIrq
);
    import ccs_pkg::*;

    // apb decode; zero wait states, byte lane 0 carries all fields
    logic access, wrEn, setup;
    logic hitMcr, hitMsr, hitTsr, hitTpr, hitRfr, hitIcr, mapped;
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wrEn    = access && pwrite && pstrb[0];
    assign hitMcr  = paddr == OFS_MASTER_CONTROL;
    assign hitMsr  = paddr == OFS_MASTER_STATUS;
    assign hitTsr  = paddr == OFS_TX_STATUS;
    assign hitTpr  = paddr == OFS_TX_PRIORITY;
    assign hitRfr  = paddr == OFS_RX_FIFO;
    assign hitIcr  = paddr == OFS_IRQ_CONTROL;
    assign mapped  = hitMcr | hitMsr | hitTsr | hitTpr | hitRfr | hitIcr;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // receive pin crosses in through two flops
    logic rxMeta_q, rxSync_q;
    always_ff @(posedge clk)
    begin
        rxMeta_q <= resetn ? canRx : 1'b1;
        rxSync_q <= resetn ? rxMeta_q : 1'b1;
    end

    // control registers
    logic [6:0] mcr_q, mcr_d;
    logic [7:0] icr_q, icr_d;
    logic autoBusoffRecovery, autoWakeup, noAutoRetx, fifoLockMode;
    logic txOrderByRequest, sleepRequest, initRequest;
    assign autoBusoffRecovery = mcr_q[MCR_AUTO_BUSOFF];
    assign autoWakeup         = mcr_q[MCR_AUTO_WAKEUP];
    assign noAutoRetx         = mcr_q[MCR_NO_RETX];
    assign fifoLockMode       = mcr_q[MCR_FIFO_LOCK];
    assign txOrderByRequest   = mcr_q[MCR_TX_ORDER];
    assign sleepRequest       = mcr_q[MCR_SLEEP_REQ];
    assign initRequest        = mcr_q[MCR_INIT_REQ];

    // mode machine
    ccs_mode_t mode_q, mode_d;
    logic busy, runHit, sleepAck, initAck, wakeSof, initHold_q, initHold_d;
    assign busy     = eng.rxActive || eng.txActive;
    assign sleepAck = mode_q == MODE_SLEEP;
    assign initAck  = mode_q == MODE_INIT || initHold_q;
    // ack holds through resync, dropping once the run ends
    assign initHold_d = initAck && mode_d == MODE_SYNC;
    assign wakeSof  = sleepAck && eng.sofSeen;

    // hardware clears the sleep request on a start of frame; a
    // simultaneous software write still wins since it is newer
    always_comb
    begin
        mcr_d = mcr_q;
        if (wakeSof && autoWakeup)
            mcr_d[MCR_SLEEP_REQ] = 1'b0;
        if (wrEn && hitMcr)
            mcr_d = pwdata[6:0];
    end

    // busoff release bit is a write pulse and reads back as zero
    always_comb
    begin
        icr_d = icr_q;
        if (wrEn && hitIcr)
            icr_d = pwdata[7:0] & 8'hc0;
    end

    // mode transitions only at frame boundaries when leaving traffic
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_SLEEP:
                if (!sleepRequest)
                    mode_d = initRequest ? MODE_INIT : MODE_SYNC;
            MODE_INIT:
                if (!initRequest)
                    mode_d = sleepRequest ? MODE_SLEEP : MODE_SYNC;
            MODE_SYNC:
                if (initRequest && !busy)
                    mode_d = MODE_INIT;
                else if (runHit)
                    mode_d = MODE_NORMAL;
            MODE_NORMAL:
                if (initRequest && !busy)
                    mode_d = MODE_INIT;
                else if (sleepRequest && !busy)
                    mode_d = MODE_SLEEP;
        endcase
    end

    // recessive run counter, shared by resync and bus-off recovery
    logic [3:0] runCnt_q, runCnt_d;
    logic [6:0] busRuns_q, busRuns_d;
    logic       busOff_q, busOff_d, busOffLast, swRecover, countOn;
    assign runHit = eng.bitTick && rxSync_q
                    && runCnt_q == RECESSIVE_RUN - 4'd1;
    assign countOn  = mode_q == MODE_SYNC || busOff_q;
    assign runCnt_d = (runHit || !countOn || eng.busOffEnter) ? 4'd0
                    : !eng.bitTick ? runCnt_q
                    : rxSync_q ? runCnt_q + 4'd1 : 4'd0;
    assign busOffLast = busRuns_q == 7'(BUSOFF_RUNS - 8'd1);
    assign swRecover  = wrEn && hitIcr && pwdata[ICR_BUSOFF_REL];
    assign busRuns_d  = !busOff_q ? 7'd0
                      : runHit ? busRuns_q + 7'd1 : busRuns_q;

    // bus-off exit is automatic or waits for software
    always_comb
    begin
        busOff_d = busOff_q;
        if (autoBusoffRecovery && runHit && busOffLast)
            busOff_d = 1'b0;
        if (!autoBusoffRecovery && swRecover)
            busOff_d = 1'b0;
        if (eng.busOffEnter)
            busOff_d = 1'b1;
    end

    // transmit mailboxes
    logic [1:0] pend_q, pend_d, txOk_q, txOk_d, done_q, done_d;
    logic [1:0] drop, clrDone, leastPrio, mbEmpty, mbCode;
    logic       firstSel_q, firstSel_d, bothPend, hiSel, lowSel;
    for (genvar i = 0; i < 2; i++)
    begin : g_mailbox
        // a failure drops the request only when retries are off
        assign drop[i] = eng.txOk[i] || eng.abortDone[i]
                         || (eng.txFail[i] && noAutoRetx);
        assign clrDone[i] = wrEn && hitTsr && pwdata[TSR_DONE_BASE + i];
        assign pend_d[i] = eng.txReq[i] || (pend_q[i] && !drop[i]);
        assign txOk_d[i] = eng.txOk[i] || (txOk_q[i]
                           && !eng.txReq[i] && !clrDone[i]);
        assign done_d[i] = (pend_q[i] && drop[i])
                           || (done_q[i] && !clrDone[i]);
        assign mbEmpty[i]   = !pend_q[i];
        assign leastPrio[i] = bothPend && (lowSel == 1'(i));
    end

    // order of service: identifier or chronological request
    assign firstSel_d = (eng.txReq[0] && !pend_q[1]) ? 1'b0
                      : (eng.txReq[1] && !pend_q[0]) ? 1'b1 : firstSel_q;
    assign bothPend = &pend_q;
    assign hiSel    = !bothPend ? pend_q[1]
                    : txOrderByRequest ? firstSel_q
                    : (eng.id1 < eng.id0);
    assign lowSel   = !hiSel;
    assign mbCode   = mbEmpty[0] ? 2'd0
                    : mbEmpty[1] ? 2'd1 : {1'b0, lowSel};

    // receive fifo bookkeeping
    logic [1:0] fifoCount_q, fifoCount_d;
    logic release_q, release_d, overrun_q, overrun_d, full_q, full_d;
    logic storeOk, storeFull, relReq, clrFull, clrOvr;
    assign storeFull = eng.rxAccepted && fifoCount_q == FIFO_DEPTH
                       && !release_q;
    assign storeOk   = eng.rxAccepted && !storeFull;
    assign relReq    = wrEn && hitRfr && pwdata[RFR_RELEASE]
                       && fifoCount_q != 2'd0;
    assign clrFull   = wrEn && hitRfr && pwdata[RFR_FULL];
    assign clrOvr    = wrEn && hitRfr && pwdata[RFR_OVERRUN];
    assign release_d = relReq || (release_q ? 1'b0 : release_q);
    assign fifoCount_d = fifoCount_q + {1'b0, storeOk}
                         - {1'b0, release_q};
    assign overrun_d = storeFull || (overrun_q && !clrOvr);
    assign full_d    = (storeOk && fifoCount_q == FIFO_DEPTH - 2'd1
                        && !release_q)
                       || (full_q && !clrFull && !release_q);

    // status flags; hardware set wins over a simultaneous clear
    logic wakeFlag_q, wakeFlag_d, errFlag_q, errFlag_d;
    assign wakeFlag_d = wakeSof || (wakeFlag_q
                        && !(wrEn && hitMsr && pwdata[MSR_WAKEUP]));
    assign errFlag_d  = eng.errorSet || (errFlag_q
                        && !(wrEn && hitMsr && pwdata[MSR_ERROR]));

    // state update; reset lands in sleep with the request set
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mcr_q       <= RST_MASTER_CONTROL[6:0];
            icr_q       <= RST_IRQ_CONTROL;
            mode_q      <= MODE_SLEEP;
            initHold_q  <= 1'b0;
            runCnt_q    <= 4'd0;
            busRuns_q   <= 7'd0;
            busOff_q    <= 1'b0;
            pend_q      <= 2'b00;
            txOk_q      <= 2'b00;
            done_q      <= 2'b00;
            firstSel_q  <= 1'b0;
            fifoCount_q <= 2'd0;
            release_q   <= 1'b0;
            overrun_q   <= 1'b0;
            full_q      <= 1'b0;
            wakeFlag_q  <= 1'b0;
            errFlag_q   <= 1'b0;
        end
        else
        begin
            mcr_q       <= mcr_d;
            icr_q       <= icr_d;
            mode_q      <= mode_d;
            initHold_q  <= initHold_d;
            runCnt_q    <= runCnt_d;
            busRuns_q   <= busRuns_d;
            busOff_q    <= busOff_d;
            pend_q      <= pend_d;
            txOk_q      <= txOk_d;
            done_q      <= done_d;
            firstSel_q  <= firstSel_d;
            fifoCount_q <= fifoCount_d;
            release_q   <= release_d;
            overrun_q   <= overrun_d;
            full_q      <= full_d;
            wakeFlag_q  <= wakeFlag_d;
            errFlag_q   <= errFlag_d;
        end
    end

    // register images
    logic [7:0] msrImg, tsrImg, tprImg, rfrImg, rdMux;
    assign msrImg = {2'b00, eng.rxActive, eng.txActive,
                     wakeFlag_q, errFlag_q, sleepAck, initAck};
    assign tsrImg = {2'b00, txOk_q, 2'b00, done_q};
    assign tprImg = {1'b0, leastPrio, 1'b0, mbEmpty, mbCode};
    assign rfrImg = {2'b00, release_q, overrun_q, full_q, 1'b0,
                     fifoCount_q};
    assign rdMux  = hitMcr ? {1'b0, mcr_q}
                  : hitMsr ? msrImg
                  : hitTsr ? tsrImg
                  : hitTpr ? tprImg
                  : hitRfr ? rfrImg
                  : hitIcr ? icr_q : 8'h00;

    // read data captured in setup, stable through the access cycle
    always_ff @(posedge clk)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= {24'h00_0000, rdMux};
    end

    // engine steering
    assign ctl.initMode      = initAck;
    assign ctl.sleepMode     = sleepAck;
    assign ctl.busOff        = busOff_q;
    assign ctl.txGo          = |pend_q && mode_q == MODE_NORMAL
                               && !busOff_q;
    assign ctl.txSel         = hiSel;
    assign ctl.fifoStore     = storeOk;
    assign ctl.fifoOverwrite = storeFull && !fifoLockMode;
    assign ctl.fifoRelease   = release_q;
    assign ctl.fifoCount     = fifoCount_q;
    // status-change interrupt from the two gated flags
    assign statusIrq = (wakeFlag_q && icr_q[ICR_WAKEUP_EN])
                     || (errFlag_q && icr_q[ICR_ERROR_EN]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_auto_busoff_exit:
        assert property (busOff_q && autoBusoffRecovery && runHit
            && busOffLast && !eng.busOffEnter |=> !busOff_q)
        else $error("bus-off not left after recessive runs");
    a_wake_clears_req:
        assert property (wakeSof && autoWakeup && !(wrEn && hitMcr)
            |=> !sleepRequest ##1 !sleepAck)
        else $error("auto wake-up did not clear sleep");
    a_single_try:
        assert property (noAutoRetx && eng.txFail[1] && pend_q[1]
            && !eng.txReq[1] |=> !pend_q[1] && done_q[1])
        else $error("failed send kept pending without retries");
    a_lock_discard:
        assert property (storeFull |-> ctl.fifoOverwrite
            == !fifoLockMode && !ctl.fifoStore)
        else $error("full fifo store handled wrongly");
    a_sleep_waits:
        assert property (mode_q == MODE_NORMAL && busy |=> !sleepAck)
        else $error("sleep entered during a frame");
    a_init_waits:
        assert property (mode_q == MODE_NORMAL && busy |=> !initAck)
        else $error("init entered during a frame");
    a_w1c_zero:
        assert property (wakeFlag_q && wrEn && hitMsr
            && !pwdata[MSR_WAKEUP] |=> wakeFlag_q)
        else $error("zero write cleared wake-up flag");
    a_low_single:
        assert property (!bothPend |-> leastPrio == 2'b00)
        else $error("lowest-priority flag with one pending");
    a_release_ignored:
        assert property (wrEn && hitRfr && pwdata[RFR_RELEASE]
            && fifoCount_q == 2'd0 && !release_q |=> !release_q)
        else $error("release on empty fifo acted");
    a_release_done:
        assert property (release_q && !eng.rxAccepted |=> !release_q
            && fifoCount_q == $past(fifoCount_q) - 2'd1)
        else $error("release did not complete in one cycle");
    a_overrun_set:
        assert property (storeFull ##1 !clrOvr |-> overrun_q [*2])
        else $error("overrun flag not held");
endmodule

// ==== sim/ccs_bus_node.sv ====
`timescale 1ns/100ps
// far-side node: paces bit samples and owns the receive level
module ccs_bus_node #(
    parameter int TICK_DIV = 16
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic domReq,
    output logic      canRx,
    output logic      bitTick
);
    int divCnt = 0;

    // termination pulls the idle bus recessive; dominant only on demand
    assign canRx = domReq ? 1'b0 : 1'b1;
    assign bitTick = resetn && divCnt == TICK_DIV - 1;

    // free-running bit timing, short so bit counts stay cheap
    always @(posedge clk)
    begin
        if (!resetn || bitTick)
            divCnt <= 0;
        else
            divCnt <= divCnt + 1;
    end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb;
    import ccs_pkg::*;
    logic            clk = 1'b0;
    logic            resetn = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [31:0]     pwdata = 32'h0;
    logic [3:0]      pstrb = 4'hf;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            canRx;
    logic            bitTick;
    logic            statusIrq;
    logic            domReq = 1'b0;
    logic            rxAct = 1'b0;
    logic            txAct = 1'b0;
    logic [10:0]     idM [2] = '{11'h000, 11'h000};
    ccs_engine_in_t  engTb = '0;
    ccs_engine_in_t  eng;
    ccs_engine_out_t ctl;
    logic            ovw;
    logic            sto;
    logic [15:0]     seed = 16'h440b; // 17419
    int              mismatches = 0;
    int              nTests = 0;
    int              fifoCnt = 0;
    logic            full = 1'b0;
    logic            ovr = 1'b0;
    logic            lockM = 1'b0;
    logic            txOrdM = 1'b0;
    logic            pend [2] = '{1'b0, 1'b0};
    int              ordQ [$];

    always #12.5 clk = ~clk;

    // bench pulses, with levels, ids and bit ticks laid over them
    always_comb
    begin
        eng = engTb;
        eng.bitTick = bitTick;
        eng.rxActive = rxAct;
        eng.txActive = txAct;
        eng.id0 = idM[0];
        eng.id1 = idM[1];
    end

    ccs_control_status ccs_control_status_inst (
        .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .canRx(canRx),
        .eng(eng), .ctl(ctl), .statusIrq(statusIrq)
    );
    ccs_bus_node ccs_bus_node_inst (
        .clk(clk), .resetn(resetn), .domReq(domReq), .canRx(canRx),
        .bitTick(bitTick)
    );

    task automatic results();
        $display("comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chkReg(input logic [7:0] got, input logic [7:0] x);
        nTests++;
        if (got !== x)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, x);
        end
    endtask

    // single status wires share the register compare
    task automatic chkSig(input logic got, input logic x);
        chkReg({7'h00, got}, {7'h00, x});
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] r,
                       output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic       e;
        apb(a, 1'b1, d, v, e);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] v;
        logic       e;
        apb(a, 1'b0, 8'h00, v, e);
        chkReg(v, x);
    endtask

    // counts bit samples; bounded so a dead tick source cannot hang
    task automatic waitTicks(input int k);
        int c;
        for (c = 0; k > 0 && c < 30000; c++)
        begin
            @(posedge clk);
            if (bitTick)
                k--;
        end
        if (k > 0)
        begin
            mismatches++;
            results();
        end
    endtask

    task automatic pulse(input int f, input logic [1:0] m);
        @(posedge clk);
        case (f)
            0: engTb.rxAccepted <= 1'b1;
            1: engTb.sofSeen <= 1'b1;
            2: engTb.errorSet <= 1'b1;
            3: engTb.busOffEnter <= 1'b1;
            4: engTb.txReq <= m;
            5: engTb.txOk <= m;
            6: engTb.txFail <= m;
            default: engTb.abortDone <= m;
        endcase
        @(posedge clk);
        ovw = ctl.fifoOverwrite;
        sto = ctl.fifoStore;
        engTb <= '0;
    endtask

    task automatic reqMb(input int m);
        pulse(4, 2'(1 << m));
        pend[m] = 1'b1;
        ordQ.push_back(m);
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // last in line: latest request, or the larger identifier
    function automatic int loMb();
        return txOrdM ? ordQ[1] : int'(idM[1] > idM[0]);
    endfunction

    function automatic logic [7:0] expPrio();
        logic [7:0] r;
        r = {4'h0, ~pend[1], ~pend[0], 2'b00};
        if (pend[0] && pend[1])
        begin
            r[5 + loMb()] = 1'b1;
            r[1:0] = 2'(loMb());
        end
        else
            r[1:0] = {1'b0, pend[0]};
        return r;
    endfunction

    task automatic accept();
        pulse(0, 2'b00);
        chkSig(ovw, fifoCnt == 3 && !lockM);
        chkSig(sto, fifoCnt < 3);
        if (fifoCnt == 3)
            ovr = 1'b1;
        else
            fifoCnt++;
        full = full || fifoCnt == 3;
        rdChk(OFS_RX_FIFO, {3'b000, ovr, full, 1'b0, 2'(fifoCnt)});
    endtask

    task automatic rel();
        int i;
        // two waiting and a frame arriving: watch the pin first
        if (fifoCnt == 2 && rxAct)
            for (i = 0; i < 8 && canRx; i++)
                waitTicks(1);
        wr(OFS_RX_FIFO, 8'h20);
        full = full && fifoCnt == 0;
        if (fifoCnt > 0)
            fifoCnt--;
        rdChk(OFS_RX_FIFO, {3'b000, ovr, full, 1'b0, 2'(fifoCnt)});
        chkReg({6'h00, ctl.fifoCount}, 8'(fifoCnt));
    endtask

    initial
    begin
        logic [7:0] v;
        logic       e;
        int         k;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rdChk(OFS_MASTER_CONTROL, 8'h02);
        rdChk(OFS_MASTER_STATUS, 8'h02);
        rdChk(OFS_TX_STATUS, 8'h00);
        rdChk(OFS_TX_PRIORITY, 8'h0c);
        rdChk(OFS_RX_FIFO, 8'h00);
        chkSig(ctl.sleepMode, 1'b1);
        apb(8'h18, 1'b0, 8'h00, v, e);
        chkSig(e, 1'b1);
        // init entry, then a resync broken by one dominant stretch
        wr(OFS_MASTER_CONTROL, 8'h01);
        rdChk(OFS_MASTER_STATUS, 8'h01);
        chkSig(ctl.initMode, 1'b1);
        wr(OFS_MASTER_CONTROL, 8'h00);
        waitTicks(6);
        domReq <= 1'b1;
        waitTicks(2);
        domReq <= 1'b0;
        waitTicks(10);
        rdChk(OFS_MASTER_STATUS, 8'h01);
        waitTicks(2);
        rdChk(OFS_MASTER_STATUS, 8'h00);
        // activity bits and the error flag with its interrupt
        rxAct <= 1'b1;
        txAct <= 1'b1;
        wr(OFS_IRQ_CONTROL, 8'hc0);
        pulse(2, 2'b00);
        rdChk(OFS_MASTER_STATUS, 8'h34);
        chkSig(statusIrq, 1'b1);
        rxAct <= 1'b0;
        txAct <= 1'b0;
        wr(OFS_MASTER_STATUS, 8'h00);
        rdChk(OFS_MASTER_STATUS, 8'h04);
        wr(OFS_MASTER_STATUS, 8'h04);
        rdChk(OFS_MASTER_STATUS, 8'h00);
        chkSig(statusIrq, 1'b0);
        // fill past full, unlocked then locked, and drain past empty
        for (k = 0; k < 2; k++)
        begin
            lockM = k[0];
            wr(OFS_MASTER_CONTROL, {4'h0, lockM, 3'b000});
            repeat (4) accept();
            if (lockM)
            begin
                wr(OFS_RX_FIFO, 8'h08);
                full = 1'b0;
            end
            wr(OFS_RX_FIFO, 8'h00);
            rdChk(OFS_RX_FIFO, {3'b000, ovr, full, 3'b011});
            wr(OFS_RX_FIFO, 8'h10);
            ovr = 1'b0;
            rxAct <= 1'b1;
            repeat (4) rel();
            rxAct <= 1'b0;
        end
        // two mailboxes under both orderings and both retry policies
        for (k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            idM[0] <= seed[10:0];
            idM[1] <= seed[10:0] ^ {seed[15:11], 6'h01};
            txOrdM = k[0];
            wr(OFS_MASTER_CONTROL, {3'b000, k[1], 1'b0, txOrdM, 2'b00});
            reqMb(1);
            rdChk(OFS_TX_PRIORITY, expPrio());
            reqMb(0);
            rdChk(OFS_TX_PRIORITY, expPrio());
            chkSig(ctl.txSel, 1'(1 - loMb()));
            chkSig(ctl.txGo, 1'b1);
            pulse(5, 2'b11);
            pend = '{1'b0, 1'b0};
            ordQ.delete();
            rdChk(OFS_TX_STATUS, 8'h33);
            wr(OFS_TX_STATUS, 8'h00);
            rdChk(OFS_TX_STATUS, 8'h33);
            wr(OFS_TX_STATUS, 8'h01);
            rdChk(OFS_TX_STATUS, 8'h22);
            reqMb(1);
            apb(OFS_TX_STATUS, 1'b0, 8'h00, v, e);
            chkReg(v & 8'h30, 8'h00);
            wr(OFS_TX_STATUS, 8'h03);
            pulse(6, 2'b10);
            if (!k[1])
            begin
                rdChk(OFS_TX_PRIORITY, expPrio());
                pulse(7, 2'b10);
            end
            pend[1] = 1'b0;
            ordQ.delete();
            rdChk(OFS_TX_STATUS, 8'h02);
            rdChk(OFS_TX_PRIORITY, 8'h0c);
            wr(OFS_TX_STATUS, 8'h02);
        end
        // sleep waits for the frame; auto wake-up on start of frame
        rxAct <= 1'b1;
        wr(OFS_MASTER_CONTROL, 8'h02);
        repeat (8) @(posedge clk);
        rdChk(OFS_MASTER_STATUS, 8'h20);
        rxAct <= 1'b0;
        repeat (3) @(posedge clk);
        rdChk(OFS_MASTER_STATUS, 8'h02);
        wr(OFS_IRQ_CONTROL, 8'h80);
        wr(OFS_MASTER_CONTROL, 8'h22);
        pulse(1, 2'b00);
        rdChk(OFS_MASTER_CONTROL, 8'h20);
        rdChk(OFS_MASTER_STATUS, 8'h08);
        chkSig(statusIrq, 1'b1);
        wr(OFS_MASTER_STATUS, 8'h08);
        repeat (3) @(posedge clk);
        chkSig(statusIrq, 1'b0);
        // bus-off left by the run count, or only by software
        wr(OFS_MASTER_CONTROL, 8'h40);
        pulse(3, 2'b00);
        waitTicks(1400);
        chkSig(ctl.busOff, 1'b1);
        waitTicks(12);
        chkSig(ctl.busOff, 1'b0);
        wr(OFS_MASTER_CONTROL, 8'h00);
        pulse(3, 2'b00);
        waitTicks(1420);
        chkSig(ctl.busOff, 1'b1);
        wr(OFS_IRQ_CONTROL, 8'h01);
        repeat (3) @(posedge clk);
        chkSig(ctl.busOff, 1'b0);
        results();
    end
endmodule
